// *** common/cac_cfg.svh ***
// Contract
// - Eight-bit arithmetic unit: add, subtract, shifts and Boolean logic.
// - Arithmetic operands and results are two's complement unless told otherwise.
// - Two-operand ops use accumulator plus a file register or immediate constant.
// - Single-operand ops take the accumulator or a file register.
// - Eight-bit accumulator feeds the unit and has no data address.
// - Carry, nibble carry and zero flags update per instruction from the result.
// - In subtraction carry means no borrow, nibble flag means no nibble borrow.
// - A whole 14-bit word is fetched per instruction cycle on a program bus.
// - Fetch of the next word overlaps execution of the current one.
// - Non-branch ops finish in one instruction cycle; branches take longer.
// - Instruction rate is oscillator over four; driven out on the rate pin in RC mode only.
// - Special registers, program counter included, live in the data map; the core keeps pc internal and never decodes their addresses.
// - Program memory spans 4K words of 14 bits; data memory 176 bytes.
// - Device is held in reset while the master reset input is low.
`ifndef CAC_CFG_SVH
`define CAC_CFG_SVH
`define CAC_DATA_W 8
`define CAC_INSTR_W 14
`define CAC_PC_W 12
`define CAC_PROG_WORDS 4096
`define CAC_DATA_BYTES 176
`define CAC_DADDR_W 8
`define CAC_OSC_PER_CYC 4
`define CAC_BRANCH_CYC 2
`define CAC_PCL_ADDR 8'h02
`define CAC_STATUS_ADDR 8'h03
`define CAC_PCLATH_ADDR 8'h0A
`define CAC_FLAG_C 0
`define CAC_FLAG_NIB 1
`define CAC_FLAG_Z 2
`define CAC_CYC_NS 500
`define CAC_OSC_MHZ 8
`endif

// *** common/cac_pkg.sv ***
package cac_pkg;
	typedef enum logic [3:0] {
		CAC_OP_NONE, CAC_OP_ADD, CAC_OP_SUB, CAC_OP_AND, CAC_OP_OR, CAC_OP_XOR,
		CAC_OP_COM, CAC_OP_INC, CAC_OP_DEC, CAC_OP_RLF, CAC_OP_RRF, CAC_OP_SWAP,
		CAC_OP_MOV, CAC_OP_CLR
	} cac_op_e;
	typedef enum logic [1:0] {CAC_SRC_FILE, CAC_SRC_IMM, CAC_SRC_ACC} cac_src_e;
	// One decoded instruction as presented by the decoder
	typedef struct packed {
		cac_op_e op;
		cac_src_e src;
		logic to_acc;
		logic wr_c;
		logic wr_nib;
		logic wr_z;
		logic branch;
		logic [7:0] faddr;
		logic [7:0] imm;
		logic [11:0] target;
	} cac_dec_s;
	// Data memory write request
	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] data;
	} cac_dwr_s;
endpackage : cac_pkg

// *** core/cac_core.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cac_cfg.svh"
module cac_core
	import cac_pkg::*;
#(
	parameter int OSC_PER_CYC = `CAC_OSC_PER_CYC,
	parameter int BRANCH_CYC = `CAC_BRANCH_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic master_reset_input_b_i,
	input wire logic rc_mode_i,
	input wire logic [`CAC_INSTR_W-1:0] prog_word_i,
	input wire cac_dec_s dec_i,
	input wire logic [`CAC_DATA_W-1:0] file_rd_i,
	output logic [`CAC_PC_W-1:0] prog_addr_o,
	output logic [`CAC_DADDR_W-1:0] file_raddr_o,
	output var cac_dwr_s dwr_o,
	output logic [`CAC_INSTR_W-1:0] exec_word_o,
	output logic exec_valid_o,
	output logic cycle_en_o,
	output logic instr_rate_output_o,
	output logic [`CAC_DATA_W-1:0] acc_o,
	output logic [2:0] flags_o
);
	typedef logic [8:0] cac_sum_t;

	logic [1:0] osc_cnt;
	logic cyc_en;
	logic in_rst;
	logic [`CAC_PC_W-1:0] pc;
	logic [`CAC_INSTR_W-1:0] fetch_reg;
	logic fetch_valid;
	logic [1:0] stall_cnt;
	logic [`CAC_DATA_W-1:0] acc;
	logic [2:0] flags;
	logic [`CAC_DATA_W-1:0] opnd;
	logic [`CAC_DATA_W-1:0] next_res;
	logic next_c;
	logic next_nib;
	logic exec_go;

	// Held in reset by either the system reset or the master reset pin
	assign in_rst = !rst_b_i || !master_reset_input_b_i;

	// Nine-bit add with nibble carry; subtraction adds the complement plus one
	function automatic logic [9:0] cac_addc(input logic [7:0] a, input logic [7:0] b, input logic ci);
		logic [4:0] lo;
		logic [4:0] hi;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
		cac_addc = {lo[4], hi[4], hi[3:0], lo[3:0]};
	endfunction : cac_addc

	// Divide the oscillator by four to get the instruction cycle enable
	always_ff @(posedge ref_clk_i) begin
		if (in_rst) begin
			osc_cnt <= 2'h0;
		end else begin
			osc_cnt <= (osc_cnt == 2'(OSC_PER_CYC - 1)) ? 2'h0 : osc_cnt + 2'h1;
		end
	end
	assign cyc_en = !in_rst && (osc_cnt == 2'(OSC_PER_CYC - 1));

	// Rate output high for the second half of each cycle, in RC mode only
	always_ff @(posedge ref_clk_i) begin
		if (in_rst) begin
			instr_rate_output_o <= 1'b0;
			cycle_en_o <= 1'b0;
		end else begin
			instr_rate_output_o <= rc_mode_i && (osc_cnt >= 2'h1) && (osc_cnt <= 2'h2);
			cycle_en_o <= cyc_en;
		end
	end

	// Operand select: file register, immediate or accumulator
	always_comb begin
		case (dec_i.src)
			CAC_SRC_IMM: opnd = dec_i.imm;
			CAC_SRC_ACC: opnd = acc;
			default: opnd = file_rd_i;
		endcase
	end

	// Arithmetic unit, two's complement wraparound on eight bits
	always_comb begin
		logic [9:0] s;
		s = 10'h000;
		next_res = 8'h00;
		next_c = flags[`CAC_FLAG_C];
		next_nib = flags[`CAC_FLAG_NIB];
		case (dec_i.op)
			CAC_OP_ADD: begin
				s = cac_addc(acc, opnd, 1'b0);
				next_res = s[7:0];
				next_c = s[8];
				next_nib = s[9];
			end
			CAC_OP_SUB: begin
				s = cac_addc(opnd, ~acc, 1'b1);
				next_res = s[7:0];
				next_c = s[8];
				next_nib = s[9];
			end
			CAC_OP_AND: next_res = acc & opnd;
			CAC_OP_OR: next_res = acc | opnd;
			CAC_OP_XOR: next_res = acc ^ opnd;
			CAC_OP_COM: next_res = ~opnd;
			CAC_OP_INC: next_res = opnd + 8'h01;
			CAC_OP_DEC: next_res = opnd - 8'h01;
			CAC_OP_RLF: begin
				next_res = {opnd[6:0], flags[`CAC_FLAG_C]};
				next_c = opnd[7];
			end
			CAC_OP_RRF: begin
				next_res = {flags[`CAC_FLAG_C], opnd[7:1]};
				next_c = opnd[0];
			end
			CAC_OP_SWAP: next_res = {opnd[3:0], opnd[7:4]};
			CAC_OP_MOV: next_res = opnd;
			default: next_res = 8'h00;
		endcase
	end

	assign exec_go = cyc_en && fetch_valid && (stall_cnt == 2'h0);

	// Fetch stage: one 14-bit word per cycle, overlapping execution
	always_ff @(posedge ref_clk_i) begin
		if (in_rst) begin
			pc <= 12'h000;
			fetch_reg <= 14'h0000;
			fetch_valid <= 1'b0;
		end else if (cyc_en) begin
			if (exec_go && dec_i.branch) begin
				pc <= dec_i.target; // Flush the prefetched word
				fetch_valid <= 1'b0;
			end else begin
				pc <= pc + 12'h001;
				fetch_reg <= prog_word_i;
				fetch_valid <= 1'b1;
			end
		end
	end

	// Branch costs an extra cycle while the pipe refills
	always_ff @(posedge ref_clk_i) begin
		if (in_rst) begin
			stall_cnt <= 2'h0;
		end else if (cyc_en) begin
			if (exec_go && dec_i.branch) begin
				stall_cnt <= 2'(BRANCH_CYC - 1);
			end else if (stall_cnt != 2'h0) begin
				stall_cnt <= stall_cnt - 2'h1;
			end
		end
	end

	// Execute stage: accumulator, flags and file write in one cycle
	always_ff @(posedge ref_clk_i) begin
		if (in_rst) begin
			acc <= 8'h00;
			flags <= 3'h0;
			dwr_o <= '0;
		end else begin
			dwr_o.we <= 1'b0;
			if (exec_go && !dec_i.branch && dec_i.op != CAC_OP_NONE) begin
				if (dec_i.to_acc) begin
					acc <= next_res;
				end else begin
					dwr_o.we <= 1'b1;
					dwr_o.addr <= dec_i.faddr;
					dwr_o.data <= next_res;
				end
				if (dec_i.wr_c) flags[`CAC_FLAG_C] <= next_c;
				if (dec_i.wr_nib) flags[`CAC_FLAG_NIB] <= next_nib;
				if (dec_i.wr_z) flags[`CAC_FLAG_Z] <= (next_res == 8'h00);
			end
		end
	end

	// Registered copies of state for the pins
	always_ff @(posedge ref_clk_i) begin
		if (in_rst) begin
			prog_addr_o <= 12'h000;
			file_raddr_o <= 8'h00;
			exec_word_o <= 14'h0000;
			exec_valid_o <= 1'b0;
			acc_o <= 8'h00;
			flags_o <= 3'h0;
		end else begin
			prog_addr_o <= pc;
			file_raddr_o <= dec_i.faddr;
			exec_word_o <= fetch_reg;
			exec_valid_o <= fetch_valid && (stall_cnt == 2'h0);
			acc_o <= acc;
			flags_o <= flags;
		end
	end

	// Shared antecedents: an accepted instruction, an add, a subtract, a branch
	sequence s_exec_op;
		exec_go && !dec_i.branch && dec_i.op != CAC_OP_NONE;
	endsequence
	sequence s_exec_add;
		s_exec_op ##0 dec_i.op == CAC_OP_ADD;
	endsequence
	sequence s_exec_sub;
		s_exec_op ##0 dec_i.op == CAC_OP_SUB;
	endsequence
	sequence s_branch;
		exec_go && dec_i.branch;
	endsequence

	// Cycle enable fires exactly once every four oscillator edges
	sequence s_cyc_gap;
		!cyc_en [*3] ##1 cyc_en;
	endsequence
	// One full instruction cycle with RC mode held on
	sequence s_rc_cycle;
		(cyc_en && rc_mode_i) ##1 rc_mode_i [*3];
	endsequence

	// Clocks since the last instruction cycle, watched by the gap check
	logic [2:0] gap_cnt;
	always_ff @(posedge ref_clk_i) begin
		if (in_rst) begin
			gap_cnt <= 3'h0;
		end else if (cyc_en) begin
			gap_cnt <= 3'h0;
		end else begin
			gap_cnt <= gap_cnt + 3'h1;
		end
	end

	// Enable spacing is four clocks
	a_cycle_rate: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		cyc_en |=> s_cyc_gap)
		else $error("cycle enable not one in four");
	// Enable comes after exactly three idle clocks
	a_cycle_gap: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		cyc_en |-> gap_cnt == 3'h3)
		else $error("cycle enable gap wrong");
	// Rate pin low two clocks, high two clocks, per cycle in RC mode
	a_rate_wave: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		s_rc_cycle |=> instr_rate_output_o && $past(instr_rate_output_o) && !$past(instr_rate_output_o, 2) && !$past(instr_rate_output_o, 3))
		else $error("rate pin shape wrong");
	// Rate pin stays quiet outside RC mode
	a_rate_off: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		!rc_mode_i |=> !instr_rate_output_o)
		else $error("rate pin active outside rc mode");
	// Cycle pin follows the internal enable one clock later
	a_cycle_pin: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		cyc_en |=> cycle_en_o)
		else $error("cycle pin missing");

	// Master reset clears the working state
	a_master_reset: assert property (@(posedge ref_clk_i)
		!master_reset_input_b_i |=> acc == 8'h00 && pc == 12'h000 && flags == 3'h0)
		else $error("master reset not honoured");

	// Zero flag tracks an all-zero result
	a_zero_flag: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		s_exec_op ##0 dec_i.wr_z |=> flags[`CAC_FLAG_Z] == ($past(next_res) == 8'h00))
		else $error("zero flag wrong");
	// Add carry is the ninth bit of the full sum
	a_add_carry: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		s_exec_add ##0 dec_i.wr_c |=> flags[`CAC_FLAG_C] == $past(cac_sum_t'({1'b0, acc} + {1'b0, opnd}) > 9'h0FF))
		else $error("add carry wrong");
	// Add nibble flag is the carry out of the low nibble
	a_add_nibble: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		s_exec_add ##0 dec_i.wr_nib |=> flags[`CAC_FLAG_NIB] == $past(5'({1'b0, acc[3:0]} + {1'b0, opnd[3:0]}) > 5'h0F))
		else $error("add nibble carry wrong");
	// Subtract carry set means no borrow
	a_sub_borrow: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		s_exec_sub ##0 dec_i.wr_c |=> flags[`CAC_FLAG_C] == $past(opnd >= acc))
		else $error("subtract borrow wrong");
	// Subtract nibble flag set means no nibble borrow
	a_sub_nibble: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		s_exec_sub ##0 dec_i.wr_nib |=> flags[`CAC_FLAG_NIB] == $past(opnd[3:0] >= acc[3:0]))
		else $error("nibble borrow wrong");
	// Subtract result wraps in two's complement
	a_sub_result: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		s_exec_sub ##0 dec_i.to_acc |=> acc == $past(opnd - acc))
		else $error("subtract result wrong");

	// Result lands in the accumulator, no file write
	a_acc_write: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		s_exec_op ##0 dec_i.to_acc |=> acc == $past(next_res) && !dwr_o.we)
		else $error("accumulator not written");
	// Result goes out as a file write
	a_file_write: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		s_exec_op ##0 !dec_i.to_acc |=> dwr_o.we && dwr_o.data == $past(next_res))
		else $error("file write missing");
	// An empty slot leaves the accumulator, flags and file memory alone
	a_refused_none: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		exec_go && !dec_i.branch && dec_i.op == CAC_OP_NONE |=> acc == $past(acc) && flags == $past(flags) && !dwr_o.we)
		else $error("empty slot changed state");

	// Fetch advances one word per cycle
	a_fetch_step: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		cyc_en && !(exec_go && dec_i.branch) |=> pc == $past(pc) + 12'h001 && fetch_reg == $past(prog_word_i))
		else $error("fetch did not advance");
	// Branch blocks execution through the next whole cycle
	a_branch_stall: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		s_branch |=> !exec_go [*7])
		else $error("branch took one cycle");
	// Branch loads the target and drops the prefetched word
	a_branch_flush: assert property (@(posedge ref_clk_i) disable iff (in_rst)
		s_branch |=> !fetch_valid && pc == $past(dec_i.target))
		else $error("branch did not flush");
endmodule : cac_core
`default_nettype wire

// *** dv/test_cpu_alu_accumulator_core.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "cac_cfg.svh"
module test_cpu_alu_accumulator_core;
	import cac_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic master_reset_input_b_i = 1'b1;
	logic rc_mode_i = 1'b1;
	logic [13:0] prog_word_i = 14'h0000;
	cac_dec_s dec_i = '0;
	logic [7:0] file_rd_i = 8'h00;
	logic [11:0] prog_addr_o;
	logic [7:0] file_raddr_o;
	cac_dwr_s dwr_o;
	logic [13:0] exec_word_o;
	logic exec_valid_o;
	logic cycle_en_o;
	logic instr_rate_output_o;
	logic [7:0] acc_o;
	logic [2:0] flags_o;
	int err_count = 0;
	int samples_checked = 0;
	// Design under test
	cac_core #(.OSC_PER_CYC(4), .BRANCH_CYC(2)) i_cac_core (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.master_reset_input_b_i(master_reset_input_b_i), .rc_mode_i(rc_mode_i), .prog_word_i(prog_word_i),
		.dec_i(dec_i), .file_rd_i(file_rd_i), .prog_addr_o(prog_addr_o), .file_raddr_o(file_raddr_o),
		.dwr_o(dwr_o), .exec_word_o(exec_word_o), .exec_valid_o(exec_valid_o), .cycle_en_o(cycle_en_o),
		.instr_rate_output_o(instr_rate_output_o), .acc_o(acc_o), .flags_o(flags_o));
	// 20 MHz clock
	always #25 ref_clk_i = ~ref_clk_i;
	task automatic end_sim;
		if (err_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Inputs move 1 ns after the rising edge
	task automatic step(input int n);
		repeat (n) begin
			@(posedge ref_clk_i);
			#1;
		end
	endtask : step
	task automatic wait_cyc;
		int k;
		k = 0;
		while (cycle_en_o !== 1'b1 && k < 12) begin
			step(1);
			k++;
		end
		if (k == 12) check(0, 1);
	endtask : wait_cyc
	// One instruction: drive the decode, then judge acc, flags, fetch and pipe
	task automatic exec(input cac_op_e op, input cac_src_e src, input logic [7:0] v, input logic [2:0] wr,
		input logic [7:0] ea, input logic [2:0] ef);
		logic [11:0] pa;
		wait_cyc();
		pa = prog_addr_o;
		dec_i.op = op;
		dec_i.src = src;
		dec_i.imm = v;
		file_rd_i = v;
		{dec_i.wr_z, dec_i.wr_nib, dec_i.wr_c} = wr;
		prog_word_i = {6'h2A, v};
		step(4);
		check(cycle_en_o, 1);
		check(prog_addr_o, pa + 12'h001);
		step(1);
		check(acc_o, ea);
		check(flags_o, ef);
		check(exec_word_o, {6'h2A, v});
		check(exec_valid_o, 1);
		check(file_raddr_o, 8'h20);
		dec_i.op = CAC_OP_NONE;
	endtask : exec
	// Rate pin toggles at a quarter of the clock only in RC mode
	task automatic rate_chk(input logic rc);
		logic [7:0] s;
		logic [7:0] e;
		rc_mode_i = rc;
		step(2);
		for (int i = 0; i < 8; i++) begin
			s[i] = instr_rate_output_o;
			e[i] = cycle_en_o;
			step(1);
		end
		check($countones(s), rc ? 4 : 0);
		check(s[3:0], s[7:4]);
		check($countones(e), 2);
	endtask : rate_chk
	// Result goes to a file register; accumulator untouched
	task automatic wr_test;
		wait_cyc();
		dec_i.op = CAC_OP_ADD;
		dec_i.src = CAC_SRC_FILE;
		file_rd_i = 8'h05;
		dec_i.to_acc = 1'b0;
		{dec_i.wr_z, dec_i.wr_nib, dec_i.wr_c} = 3'b000;
		step(4);
		check(dwr_o, {1'b1, 8'h20, 8'h05});
		check(acc_o, 8'h00);
		dec_i.op = CAC_OP_NONE;
		dec_i.to_acc = 1'b1;
		step(1);
		check(dwr_o.we, 0);
	endtask : wr_test
	// Branch loads the counter; the next slot is dropped
	task automatic br_test;
		wait_cyc();
		dec_i.branch = 1'b1;
		dec_i.target = 12'h123;
		step(5);
		check(prog_addr_o, 12'h123);
		check(exec_valid_o, 0);
		dec_i.branch = 1'b0;
		dec_i.op = CAC_OP_ADD;
		dec_i.src = CAC_SRC_IMM;
		dec_i.imm = 8'h01;
		{dec_i.wr_z, dec_i.wr_nib, dec_i.wr_c} = 3'b111;
		step(4);
		check({acc_o, flags_o}, {8'h00, 3'b111});
		dec_i.op = CAC_OP_NONE;
	endtask : br_test
	// Master reset mid-run, then restart timing
	task automatic rst_test;
		int k;
		master_reset_input_b_i = 1'b0;
		step(2);
		check({acc_o, flags_o, cycle_en_o, dwr_o.we}, 0);
		master_reset_input_b_i = 1'b1;
		k = 0;
		do begin
			step(1);
			k++;
		end while (cycle_en_o !== 1'b1 && k < 12);
		check(k, 4);
	endtask : rst_test
	// Main sequence
	initial begin
		dec_i.to_acc = 1'b1;
		dec_i.faddr = 8'h20;
		repeat (10) @(posedge ref_clk_i);
		#1;
		rst_b_i = 1'b1;
		rate_chk(1'b1);
		rate_chk(1'b0);
		exec(CAC_OP_MOV, CAC_SRC_IMM, 8'h0F, 3'b100, 8'h0F, 3'b000);
		exec(CAC_OP_ADD, CAC_SRC_IMM, 8'h01, 3'b111, 8'h10, 3'b010);
		exec(CAC_OP_ADD, CAC_SRC_IMM, 8'hF0, 3'b111, 8'h00, 3'b101);
		exec(CAC_OP_SUB, CAC_SRC_IMM, 8'h05, 3'b111, 8'h05, 3'b011);
		exec(CAC_OP_SUB, CAC_SRC_IMM, 8'h03, 3'b111, 8'hFE, 3'b000);
		exec(CAC_OP_AND, CAC_SRC_IMM, 8'h0F, 3'b100, 8'h0E, 3'b000);
		exec(CAC_OP_OR, CAC_SRC_IMM, 8'hF0, 3'b100, 8'hFE, 3'b000);
		exec(CAC_OP_XOR, CAC_SRC_IMM, 8'hFE, 3'b100, 8'h00, 3'b100);
		exec(CAC_OP_COM, CAC_SRC_ACC, 8'h00, 3'b100, 8'hFF, 3'b000);
		exec(CAC_OP_ADD, CAC_SRC_FILE, 8'h01, 3'b111, 8'h00, 3'b111);
		exec(CAC_OP_INC, CAC_SRC_ACC, 8'h00, 3'b100, 8'h01, 3'b011);
		exec(CAC_OP_DEC, CAC_SRC_ACC, 8'h00, 3'b100, 8'h00, 3'b111);
		exec(CAC_OP_MOV, CAC_SRC_IMM, 8'h81, 3'b100, 8'h81, 3'b011);
		exec(CAC_OP_RLF, CAC_SRC_ACC, 8'h00, 3'b001, 8'h03, 3'b011);
		exec(CAC_OP_RRF, CAC_SRC_ACC, 8'h00, 3'b001, 8'h81, 3'b011);
		exec(CAC_OP_SWAP, CAC_SRC_ACC, 8'h00, 3'b000, 8'h18, 3'b011);
		exec(CAC_OP_CLR, CAC_SRC_ACC, 8'h00, 3'b100, 8'h00, 3'b111);
		wr_test();
		br_test();
		rst_test();
		exec(CAC_OP_MOV, CAC_SRC_IMM, 8'h7F, 3'b100, 8'h7F, 3'b000);
		exec(CAC_OP_ADD, CAC_SRC_IMM, 8'h01, 3'b111, 8'h80, 3'b010);
		end_sim();
	end
	// Watchdog on a hang
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		err_count++;
		end_sim();
	end
endmodule : test_cpu_alu_accumulator_core
`default_nettype wire
